// ===== design/iwd_pkg.sv
/*
  iwd_pkg: field layout, opcode patterns and timing counts for the
  instruction word decoder and its phase sequencer.
  Assumes nothing of its surroundings.
*/
package iwd_pkg;
  localparam int unsigned IWD_WORD_W     = 12;
  localparam int unsigned IWD_FILE_W     = 7;
  localparam int unsigned IWD_LIT_W      = 9;
  localparam int unsigned IWD_OPC_W      = 6;
  localparam int unsigned IWD_PHASE_W    = 2;
  // oscillator periods per instruction cycle
  localparam int unsigned IWD_PHASES     = 4;
  localparam logic [1:0]  IWD_PH_FIRST   = 2'h0;
  localparam logic [1:0]  IWD_PH_LAST    = 2'(IWD_PHASES - 1);
  // field positions
  localparam int unsigned IWD_FSEL_MSB   = 4;
  localparam int unsigned IWD_DEST_POS   = 5;
  localparam int unsigned IWD_BSEL_LSB   = 5;
  localparam int unsigned IWD_BSEL_MSB   = 7;
  localparam int unsigned IWD_LIT8_MSB   = 7;
  localparam int unsigned IWD_LIT9_MSB   = 8;
  localparam int unsigned IWD_CTL_LSB    = 5;
  // opcode patterns, most significant bits
  localparam logic [1:0]  IWD_GRP_BYTE_P = 2'h0;
  localparam logic [1:0]  IWD_GRP_BIT_P  = 2'h1;
  localparam logic [6:0]  IWD_CTL_P      = 7'h00;
  localparam logic [2:0]  IWD_GOTO_P     = 3'h5;
  localparam logic [3:0]  IWD_CALL_P     = 4'h9;
  localparam logic [3:0]  IWD_RETLW_P    = 4'h8;
  localparam logic [1:0]  IWD_LITW_P     = 2'h3;
  localparam logic [5:0]  IWD_DECFSZ_P   = 6'h0b;
  localparam logic [5:0]  IWD_INCFSZ_P   = 6'h0f;
  localparam logic [2:0]  IWD_BTFS_P     = 3'h3;
  localparam logic [3:0]  IWD_BSET_CLR_P = 4'h4;
  // file address of the program counter low byte
  localparam logic [4:0]  IWD_PCL_ADDR   = 5'h02;
  localparam logic [6:0]  IWD_FILE_MIN   = 7'h00;
  localparam logic [6:0]  IWD_FILE_MAX   = 7'h7f;

  typedef enum logic [1:0] {
    IWD_GRP_BYTE,
    IWD_GRP_BIT,
    IWD_GRP_LITCTL
  } iwd_group_t;
endpackage

// ===== design/iwd_phase_if.sv
/*
  iwd_phase_if: carries the phase number and cycle boundary strobes from
  the phase sequencer to the decoder.
  Assumes both ends share one clock.
*/
`timescale 1ns/10ps
interface iwd_phase_if;
  logic [1:0] phase;
  logic       first;
  logic       last;
  modport gen (output phase, output first, output last);
  modport sink (input phase, input first, input last);
endinterface

// ===== design/iwd_phase_gen.sv
/*
  iwd_phase_gen: counts oscillator periods into instruction cycles.
  Assumes clk_i is the core oscillator and rst_i is synchronous.
*/
`timescale 1ns/10ps
module iwd_phase_gen
  import iwd_pkg::*;
(
  input  wire logic clk_i,    // core oscillator
  input  wire logic rst_i,    // synchronous reset, active high
  iwd_phase_if.gen  ph        // phase and cycle strobes
);
  typedef struct packed {
    logic [1:0] phase;
    logic       first;
    logic       last;
  } iwd_ph_state_t;

  iwd_ph_state_t st;
  iwd_ph_state_t next_st;

  always_comb begin
    next_st       = st;
    next_st.phase = st.phase + 2'h1;                   // RQ9
    next_st.first = (next_st.phase == IWD_PH_FIRST);
    next_st.last  = (next_st.phase == IWD_PH_LAST);
  end

  // reset parks on the last phase so the first cycle starts right after release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '{phase: IWD_PH_LAST, first: 1'b0, last: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign ph.phase = st.phase;
  assign ph.first = st.first;
  assign ph.last  = st.last;
endmodule

// ===== design/instr_word_decode_timing.sv
/*
  instr_word_decode_timing: splits each instruction word into opcode and
  operand fields, names the result destination and sets the cycle timing.
  Assumes program memory on the same clock presents the word on instr_i by
  the end of the clock in which fetch_o is high, and that the execute unit
  gives the skip test result on skip_true_i during phase 2, the clock before fetch_o.
*/
// What this block does
// RQ1 - each 12-bit word is split into an opcode and one or more operand fields.
// RQ2 - every word is classed as a byte, bit, or literal and control operation.
// RQ3 - byte operations use the file field and send the result to W on 0, to the file on 1.
// RQ4 - bit operations take a bit number within an 8-bit file and the file from the file field.
// RQ5 - literal and control operations yield an 8-bit literal, or a 9-bit one for the branch.
// RQ6 - the file address output spans 0x00 to 0x7f; the code drives only 0x00 to 0x1f, with the upper two bits held at zero.
// RQ7 - don't-care bit positions never change the decode; tools should fill them with zero.
// RQ8 - one cycle per instruction, or two when it loads the program counter or a skip holds.
// RQ9 - one instruction cycle is four oscillator periods.
// RQ10 - every program counter write except the unconditional branch clears its bit 8.
// RQ11 - the opcode sits in the top bits and operands fill the low bits.
`timescale 1ns/10ps
module instr_word_decode_timing
  import iwd_pkg::*;
(
  input  wire logic                   clk_i,           // core oscillator
  input  wire logic                   rst_i,           // synchronous reset, active high
  input  wire logic [IWD_WORD_W-1:0]  instr_i,         // word from program memory
  input  wire logic                   skip_true_i,     // skip test result, phase 2
  output logic      [1:0]             phase_o,         // oscillator phase in cycle
  output logic                        fetch_o,         // instr_i taken at end of this clock
  output logic                        exec_valid_o,    // decoded word is executing
  output logic                        flush_o,         // second cycle of a two-cycle op
  output iwd_group_t                  group_o,         // instruction class
  output logic      [IWD_OPC_W-1:0]   opcode_o,        // top opcode bits
  output logic      [IWD_FILE_W-1:0]  file_sel_o,      // file register address
  output logic                        dest_file_o,     // result goes to file register
  output logic      [2:0]             bit_sel_o,       // bit number in file register
  output logic      [IWD_LIT_W-1:0]   literal_o,       // literal operand
  output logic                        lit9_o,          // literal is 9 bits wide
  output logic                        write_w_o,       // result written to W
  output logic                        write_file_o,    // result written to file
  output logic                        skip_op_o,       // conditional skip instruction
  output logic                        pc_write_o,      // instruction loads the PC
  output logic                        pc_bit8_clear_o  // force PC bit 8 to zero
);
  typedef struct packed {
    logic [1:0]            phase;
    logic                  fetch;
    logic                  exec_valid;
    logic                  flush;
    logic                  flush_pend;
    iwd_group_t            group;
    logic [IWD_OPC_W-1:0]  opcode;
    logic [IWD_FILE_W-1:0] file_sel;
    logic                  dest_file;
    logic [2:0]            bit_sel;
    logic [IWD_LIT_W-1:0]  literal;
    logic                  lit9;
    logic                  write_w;
    logic                  write_file;
    logic                  skip_op;
    logic                  pc_write;
    logic                  pc_bit8_clear;
  } iwd_state_t;

  iwd_phase_if ph ();

  iwd_phase_gen u_phase (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ph    (ph)
  );

  iwd_state_t st;
  iwd_state_t next_st;

  // the control words share the byte prefix, so they are checked first
  function automatic iwd_group_t iwd_class(input logic [IWD_WORD_W-1:0] w);
    if (w[11:IWD_CTL_LSB] == IWD_CTL_P) begin
      return IWD_GRP_LITCTL;
    end else if (w[11:10] == IWD_GRP_BYTE_P) begin
      return IWD_GRP_BYTE;
    end else if (w[11:10] == IWD_GRP_BIT_P) begin
      return IWD_GRP_BIT;
    end
    return IWD_GRP_LITCTL;
  endfunction

  function automatic logic iwd_is_skip(input logic [IWD_WORD_W-1:0] w);
    return (w[11:6] == IWD_DECFSZ_P) || (w[11:6] == IWD_INCFSZ_P) ||
           (w[11:9] == IWD_BTFS_P);
  endfunction

  function automatic logic iwd_is_goto(
    input logic [IWD_WORD_W-1:0] w,
    input iwd_group_t            grp
  );
    return (grp == IWD_GRP_LITCTL) && (w[11:9] == IWD_GOTO_P);
  endfunction

  function automatic logic [IWD_FILE_W-1:0] iwd_file_field(
    input logic [IWD_WORD_W-1:0] w,
    input iwd_group_t            grp
  );
    if (grp == IWD_GRP_LITCTL) begin
      return IWD_FILE_MIN;
    end
    return {2'h0, w[IWD_FSEL_MSB:0]};
  endfunction

  function automatic logic [2:0] iwd_bit_field(
    input logic [IWD_WORD_W-1:0] w,
    input iwd_group_t            grp
  );
    if (grp == IWD_GRP_BIT) begin
      return w[IWD_BSEL_MSB:IWD_BSEL_LSB];
    end
    return 3'h0;
  endfunction

  // only the unconditional branch needs the ninth literal bit
  function automatic logic [IWD_LIT_W-1:0] iwd_literal(
    input logic [IWD_WORD_W-1:0] w,
    input iwd_group_t            grp
  );
    if (iwd_is_goto(w, grp)) begin
      return w[IWD_LIT9_MSB:0];
    end
    return {1'b0, w[IWD_LIT8_MSB:0]};
  endfunction

  function automatic logic iwd_writes_w(
    input logic [IWD_WORD_W-1:0] w,
    input iwd_group_t            grp
  );
    if (grp == IWD_GRP_BYTE) begin
      return !w[IWD_DEST_POS];
    end
    if (grp == IWD_GRP_LITCTL) begin
      return (w[11:10] == IWD_LITW_P) || (w[11:8] == IWD_RETLW_P);
    end
    return 1'b0;
  endfunction

  // bit set and bit clear rewrite the whole file; bit tests only read it
  function automatic logic iwd_writes_file(
    input logic [IWD_WORD_W-1:0] w,
    input iwd_group_t            grp
  );
    if (grp == IWD_GRP_BYTE) begin
      return w[IWD_DEST_POS];
    end
    if (grp == IWD_GRP_BIT) begin
      return w[11:8] inside {IWD_BSET_CLR_P, 4'h5};
    end
    return 1'b0;
  endfunction

  logic [IWD_WORD_W-1:0] w;
  iwd_group_t            grp;
  logic                  is_goto;
  logic                  is_call;
  logic                  is_retlw;
  logic                  wr_file;
  logic                  pcl_wr;

  always_comb begin
    w        = instr_i;
    grp      = iwd_class(w);                                           // RQ2
    is_goto  = iwd_is_goto(w, grp);
    is_call  = (grp == IWD_GRP_LITCTL) && (w[11:8] == IWD_CALL_P);
    is_retlw = (grp == IWD_GRP_LITCTL) && (w[11:8] == IWD_RETLW_P);
    wr_file  = iwd_writes_file(w, grp);                                // RQ3
    pcl_wr   = wr_file && (w[IWD_FSEL_MSB:0] == IWD_PCL_ADDR);

    next_st       = st;
    next_st.phase = ph.phase;
    next_st.fetch = ph.last;
    if (ph.last) begin
      // a taken skip or a PC load turns the following cycle into a flush
      next_st.flush_pend = st.exec_valid &&                            // RQ8
                           (st.pc_write || (st.skip_op && skip_true_i));
    end
    if (ph.first) begin
      next_st.flush      = st.flush_pend;                              // RQ8
      next_st.exec_valid = !st.flush_pend;
      next_st.flush_pend = 1'b0;
      next_st.group      = grp;
      next_st.opcode     = w[11:11-IWD_OPC_W+1];                       // RQ11 RQ1
      // control words carry a tiny selector in the low bits; the rest is don't-care
      next_st.file_sel   = iwd_file_field(w, grp);                     // RQ6 RQ7
      next_st.dest_file  = (grp == IWD_GRP_BYTE) && w[IWD_DEST_POS];   // RQ3
      next_st.bit_sel    = iwd_bit_field(w, grp);                      // RQ4
      next_st.lit9       = is_goto;                                    // RQ5
      next_st.literal    = iwd_literal(w, grp);                        // RQ5
      next_st.write_w    = iwd_writes_w(w, grp);                       // RQ3
      next_st.write_file = wr_file;
      next_st.skip_op    = iwd_is_skip(w);
      next_st.pc_write   = is_goto || is_call || is_retlw || pcl_wr;  // RQ8
      next_st.pc_bit8_clear = is_call || is_retlw || pcl_wr;         // RQ10
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '{phase: IWD_PH_LAST, group: IWD_GRP_BYTE, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign phase_o         = st.phase;
  assign fetch_o         = st.fetch;
  assign exec_valid_o    = st.exec_valid;
  assign flush_o         = st.flush;
  assign group_o         = st.group;
  assign opcode_o        = st.opcode;
  assign file_sel_o      = st.file_sel;
  assign dest_file_o     = st.dest_file;
  assign bit_sel_o       = st.bit_sel;
  assign literal_o       = st.literal;
  assign lit9_o          = st.lit9;
  assign write_w_o       = st.write_w;
  assign write_file_o    = st.write_file;
  assign skip_op_o       = st.skip_op;
  assign pc_write_o      = st.pc_write;
  assign pc_bit8_clear_o = st.pc_bit8_clear;
endmodule

// ===== verif/iwd_prog_mem.sv
/*
  iwd_prog_mem: program memory model that shows the word queued by the bench.
  Assumes phase_i is the decoder's phase output on the same clock.
*/
`timescale 1ns/10ps
module iwd_prog_mem (
  input  wire logic        clk_i,   // core clock
  input  wire logic [1:0]  phase_i, // decoder phase
  input  wire logic [11:0] word_i,  // next word
  output logic      [11:0] instr_o  // word to decoder
);
  initial instr_o = 12'h000;
  // a new word lands in phase 3 and stands a full cycle, so it spans the latch edge
  always @(negedge clk_i) begin
    if (phase_i == 2'h3) begin
      instr_o <= word_i;
    end
  end
endmodule

// ===== verif/iwd_checker_assertions.sv
/*
  iwd_checker: timing and field checks on the decoder ports.
  Assumes the word on instr_i stands from phase 3 to the next phase 2.
*/
`timescale 1ns/10ps
module iwd_checker
  import iwd_pkg::*;
(
  input wire logic        clk_i,          // clock
  input wire logic        rst_i,          // reset
  input wire logic [11:0] instr_i,        // word
  input wire logic [1:0]  phase_o,        // phase
  input wire logic        fetch_o,        // fetch
  input wire logic        exec_valid_o,   // executes
  input wire logic        flush_o,        // flush
  input wire iwd_group_t  group_o,        // class
  input wire logic [5:0]  opcode_o,       // opcode
  input wire logic [6:0]  file_sel_o,     // file
  input wire logic        dest_file_o,    // dest
  input wire logic [2:0]  bit_sel_o,      // bit
  input wire logic [8:0]  literal_o,      // literal
  input wire logic        lit9_o,         // wide literal
  input wire logic        pc_write_o,     // pc load
  input wire logic        pc_bit8_clear_o // bit 8 clear
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic dec_ok;
  assign dec_ok = (phase_o == 2'h2) && (exec_valid_o || flush_o);
  a_phase_seq: assert property (
    phase_o == 2'h0 |=> phase_o == 2'h1 ##1 phase_o == 2'h2 ##1 phase_o == 2'h3)
    else $error("phase order broken");
  a_fetch_period: assert property (fetch_o |=> !fetch_o [*3] ##1 fetch_o)
    else $error("fetch not once per four clocks");
  a_opcode_top: assert property (dec_ok |-> opcode_o == instr_i[11:6])
    else $error("opcode field wrong");
  a_group_class: assert property (
    dec_ok |-> group_o == ((instr_i[11:5] == 7'h00 || instr_i[11])
    ? IWD_GRP_LITCTL : (instr_i[10] ? IWD_GRP_BIT : IWD_GRP_BYTE)))
    else $error("class wrong");
  a_byte_dest: assert property (
    dec_ok && group_o == IWD_GRP_BYTE |-> dest_file_o == instr_i[5]
    && file_sel_o == {2'h0, instr_i[4:0]})
    else $error("byte fields wrong");
  a_bit_field: assert property (
    dec_ok && group_o == IWD_GRP_BIT |-> bit_sel_o == instr_i[7:5]
    && file_sel_o == {2'h0, instr_i[4:0]})
    else $error("bit fields wrong");
  a_lit_field: assert property (
    dec_ok && group_o == IWD_GRP_LITCTL |-> lit9_o == (instr_i[11:9] == 3'h5)
    && literal_o == (lit9_o ? instr_i[8:0] : {1'h0, instr_i[7:0]}))
    else $error("literal wrong");
  a_pc_bit8: assert property (
    dec_ok && exec_valid_o |-> pc_bit8_clear_o == (pc_write_o && instr_i[11:9] != 3'h5))
    else $error("pc bit 8 clear wrong");
  a_two_cycle: assert property (
    phase_o == 2'h1 && exec_valid_o && pc_write_o |-> ##4 flush_o && !exec_valid_o)
    else $error("pc write without second cycle");
  c_flush: cover property (flush_o);
  c_lit9: cover property (dec_ok && lit9_o);
  c_bit: cover property (dec_ok && group_o == IWD_GRP_BIT);
endmodule

bind instr_word_decode_timing iwd_checker u_iwd_chk (
  .clk_i(clk_i), .rst_i(rst_i), .instr_i(instr_i), .phase_o(phase_o), .fetch_o(fetch_o),
  .exec_valid_o(exec_valid_o), .flush_o(flush_o), .group_o(group_o), .opcode_o(opcode_o),
  .file_sel_o(file_sel_o), .dest_file_o(dest_file_o), .bit_sel_o(bit_sel_o),
  .literal_o(literal_o), .lit9_o(lit9_o), .pc_write_o(pc_write_o),
  .pc_bit8_clear_o(pc_bit8_clear_o));

// ===== verif/tb.sv
/*
  tb: table of words with expected class, writes and cycle counts, then reset.
  Assumes the decoder and the program memory model share clk_i.
*/
`timescale 1ns/10ps
module tb;
  import iwd_pkg::*;
  // e = {class, to W, to file, skip op, pc write, bit 8 clear}
  typedef struct packed { logic [11:0] w; logic st; logic [6:0] e; } iwd_row_t;
  iwd_row_t rows [21] = '{
    '{12'h1ff, 1'h0, 7'h08}, '{12'h1c5, 1'h0, 7'h10}, '{12'h5a7, 1'h0, 7'h28},
    '{12'h6a7, 1'h1, 7'h24}, '{12'hc3c, 1'h0, 7'h50}, '{12'ha3f, 1'h0, 7'h42},
    '{12'h000, 1'h0, 7'h40}, '{12'h902, 1'h0, 7'h43}, '{12'h004, 1'h0, 7'h40},
    '{12'h822, 1'h0, 7'h53}, '{12'hd55, 1'h0, 7'h50}, '{12'h022, 1'h0, 7'h0b},
    '{12'h6a7, 1'h1, 7'h24}, '{12'h2c5, 1'h0, 7'h14}, '{12'h3e5, 1'h1, 7'h0c},
    '{12'hff0, 1'h0, 7'h50}, '{12'h006, 1'h0, 7'h40}, '{12'h00e, 1'h0, 7'h40},
    '{12'h7e0, 1'h0, 7'h24}, '{12'h443, 1'h0, 7'h28}, '{12'he12, 1'h0, 7'h50}};
  logic        clk_i, rst_i, skip_true_i, fetch_o, exec_valid_o, flush_o, dest_file_o, ef;
  logic        lit9_o, write_w_o, write_file_o, skip_op_o, pc_write_o, pc_bit8_clear_o;
  logic [11:0] word, instr_i;
  logic [1:0]  phase_o;
  logic [5:0]  opcode_o;
  logic [6:0]  file_sel_o;
  logic [2:0]  bit_sel_o;
  logic [8:0]  literal_o, seen_v;
  iwd_group_t  group_o;
  int          num_errors = 0;
  int          check_count = 0;
  assign seen_v = {group_o, write_w_o, write_file_o, skip_op_o, pc_write_o, pc_bit8_clear_o,
                   flush_o, exec_valid_o};
  iwd_prog_mem u_mem (.clk_i(clk_i), .phase_i(phase_o), .word_i(word), .instr_o(instr_i));
  instr_word_decode_timing DUT (
    .clk_i(clk_i), .rst_i(rst_i), .instr_i(instr_i), .skip_true_i(skip_true_i),
    .phase_o(phase_o), .fetch_o(fetch_o), .exec_valid_o(exec_valid_o), .flush_o(flush_o),
    .group_o(group_o), .opcode_o(opcode_o), .file_sel_o(file_sel_o),
    .dest_file_o(dest_file_o), .bit_sel_o(bit_sel_o), .literal_o(literal_o),
    .lit9_o(lit9_o), .write_w_o(write_w_o), .write_file_o(write_file_o),
    .skip_op_o(skip_op_o), .pc_write_o(pc_write_o), .pc_bit8_clear_o(pc_bit8_clear_o));
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // queue the next word, then judge this word in its phase 2
  task automatic run_row(input iwd_row_t r);
    word = r.w;
    do @(negedge clk_i); while (phase_o !== 2'h2);
    skip_true_i = r.st;
    if (ef) begin
      chk({7'h0, seen_v[1:0]}, 9'h002);
    end else begin
      chk(seen_v, {r.e, 2'h1});
    end
    // a flush cycle may not start another one, even on a true skip test
    ef = !ef && (r.e[1] || (r.e[2] && r.st));
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // about 120 cycles are needed; twenty times that means a hang
  initial begin
    #24000;
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    test_done();
  end
  initial begin
    rst_i = 1'b1;
    skip_true_i = 1'b0;
    ef = 1'b0;
    word = rows[0].w;
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    foreach (rows[i]) run_row(rows[i]);
    $display("table test done");
    rst_i = 1'b1;
    word = rows[5].w;
    repeat (2) @(negedge clk_i);
    chk({1'h0, phase_o, fetch_o, exec_valid_o, flush_o, group_o, write_w_o}, 9'h0c0);
    rst_i = 1'b0;
    ef = 1'b0;
    run_row(rows[5]);
    run_row(rows[6]);
    $display("mid-run reset test done");
    test_done();
  end
endmodule
